// ---- design/cfa_core.v ----
// cfa_core.v: condition flags and operand address formation of the cpu.
// assumes a classic wishbone master on clk_i and a sequencer that pulses
// boundary_i at each instruction boundary.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "cfa_defs.vh"

// What this block does
// (RULE1) flags bits 6 and 5 always one
// (RULE2) sign_error_bit set on signed overflow
// (RULE3) nibble_carry set on carry bit3 to bit4
// (RULE4) bcd_adjust_op corrects accumulator to packed decimal
// (RULE5) masked_flag set blocks maskable interrupts
// (RULE6) interrupt entry sets masked_flag after stacking
// (RULE7) no interrupt right after mask clear
// (RULE8) msb_flag follows result bit 7
// (RULE9) load or store copies value msb
// (RULE10) null_result_flag set on zero result
// (RULE11) load or store zero sets null flag
// (RULE12) borrow_out_flag on carry out or borrow
// (RULE13) bit test, shifts, rotates drive borrow flag
// (RULE14) one 16-bit linear address space
// (RULE15) move source and destination modes independent
// (RULE16) test operand by mode, branch relative
// (RULE17) register_only_mode makes no memory access
// (RULE18) branch offset sign-extended, added to pc
// (RULE19) inline 16-bit operand high byte first
// (RULE20) zero_page_mode prefixes a zero high byte
// (RULE21) unaffected flags keep their value
module cfa_core (
    // clock and reset
    input  wire        clk_i,
    input  wire        reset_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // interrupt gating toward the sequencer
    input  wire        irq_req_i,
    input  wire        boundary_i,
    output reg         irq_take_o,
    output reg         irq_mask_o
);

    // architectural state
    reg  [7:0]  flags_r;       // flags_register
    reg  [7:0]  acc_r;         // accumulator operand and result
    reg  [7:0]  opb_r;         // second operand, from memory or register
    reg  [15:0] bytes_r;       // bytes after opcode, [15:8] first
    reg  [3:0]  mode_r;        // [1:0] source mode, [3:2] destination
    reg  [15:0] pc_r;          // program counter
    reg  [8:0]  cmd_r;         // last command written
    reg  [15:0] res_r;         // last result
    reg         inhibit_r;     // one boundary without interrupts
    reg         taken_r;       // last branch decision

    // next values
    reg  [7:0]  flags_nxt;
    reg  [7:0]  acc_nxt;
    reg  [7:0]  opb_nxt;
    reg  [15:0] bytes_nxt;
    reg  [3:0]  mode_nxt;
    reg  [15:0] pc_nxt;
    reg  [8:0]  cmd_nxt;
    reg  [15:0] res_nxt;
    reg         inhibit_nxt;
    reg         taken_nxt;
    reg  [31:0] rd_nxt;

    // arithmetic scratch
    reg  [8:0]  sum9;
    reg  [4:0]  sum5;
    reg  [8:0]  dif9;
    reg  [7:0]  r8;
    reg  [7:0]  corr;
    reg         cin;
    reg         cond;
    reg         lo_fix;
    reg         hi_fix;

    // bus decode: a request is taken once, while ack is low
    wire        req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr     = req & wb_we_i;
    wire        cmd_wr = wr & (wb_adr_i == `CFA_OFS_CMD) & wb_sel_i[0];
    wire [4:0]  op     = cmd_wr ? wb_dat_i[`CFA_CMD_OP_HI:0] : cmd_r[4:0];

    // effective addresses for each side of a move
    wire [16:0] src_ea = cfa_ea(mode_r[1:0], bytes_r[15:8], pc_r);
    wire [16:0] dst_ea = cfa_ea(mode_r[3:2], bytes_r[7:0], pc_r);

    // forms {access, address} for one operand; all targets share one
    // 16-bit space, so registers and ports are reached alike [RULE14]
    function [16:0] cfa_ea;
        input [1:0]  mode;
        input [7:0]  abyte;
        input [15:0] pc;
        begin
            case (mode)
                `CFA_MODE_REG:    cfa_ea = 17'h00000;        // [RULE17]
                `CFA_MODE_BRANCH: cfa_ea = {1'b1, pc + 16'h0001};
                `CFA_MODE_INLINE: cfa_ea = {1'b1, pc + 16'h0001};
                `CFA_MODE_ZPAGE:  cfa_ea = {1'b1, 8'h00, abyte}; // [RULE20]
                default:          cfa_ea = 17'h00000;
            endcase
        end
    endfunction

    // merges written byte lanes into a 16-bit register
    function [15:0] cfa_merge16;
        input [15:0] old;
        input [31:0] dat;
        input [3:0]  sel;
        begin
            cfa_merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
            cfa_merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
        end
    endfunction

    // forces the fixed-one bits; every flags update goes through it
    function [7:0] cfa_fix;
        input [7:0] f;
        begin
            cfa_fix = f | `CFA_ONES_MASK;                    // [RULE1]
        end
    endfunction

    // next-state logic: bus writes, then the commanded operation
    always @* begin
        flags_nxt   = flags_r;                               // [RULE21]
        acc_nxt     = acc_r;
        opb_nxt     = opb_r;
        bytes_nxt   = bytes_r;
        mode_nxt    = mode_r;
        pc_nxt      = pc_r;
        cmd_nxt     = cmd_r;
        res_nxt     = res_r;
        taken_nxt   = taken_r;
        inhibit_nxt = inhibit_r;
        cin         = 1'b0;
        corr        = 8'h00;
        lo_fix      = 1'b0;
        hi_fix      = 1'b0;
        r8          = 8'h00;
        cond        = 1'b0;
        // plain register writes; unmapped offsets are ignored
        if (wr) begin
            case (wb_adr_i)
                `CFA_OFS_FLAGS: if (wb_sel_i[0]) begin
                    flags_nxt = cfa_fix(wb_dat_i[7:0]);
                end
                `CFA_OFS_ACC:   if (wb_sel_i[0]) begin
                    acc_nxt = wb_dat_i[7:0];
                end
                `CFA_OFS_OPB:   if (wb_sel_i[0]) begin
                    opb_nxt = wb_dat_i[7:0];
                end
                `CFA_OFS_BYTES: bytes_nxt = cfa_merge16(bytes_r, wb_dat_i,
                                                        wb_sel_i);
                `CFA_OFS_MODE:  if (wb_sel_i[0]) begin
                    mode_nxt = wb_dat_i[3:0];
                end
                `CFA_OFS_PC:    pc_nxt = cfa_merge16(pc_r, wb_dat_i,
                                                     wb_sel_i);
                `CFA_OFS_CMD:   if (wb_sel_i[0]) begin
                    cmd_nxt = {wb_sel_i[1] & wb_dat_i[8], wb_dat_i[7:0]};
                end
                default: ;
            endcase
        end
        // the inhibit window lasts up to the next boundary
        if (boundary_i) begin
            inhibit_nxt = 1'b0;
        end
        // carry-in only for the with-carry forms
        if (op == `CFA_OP_ADC || op == `CFA_OP_SBC) begin
            cin = flags_r[`CFA_BORROW];
        end
        sum9 = {1'b0, acc_r} + {1'b0, opb_r} + {8'h00, cin};
        sum5 = {1'b0, acc_r[3:0]} + {1'b0, opb_r[3:0]} + {4'h0, cin};
        dif9 = {1'b0, acc_r} - {1'b0, opb_r} - {8'h00, cin};
        if (cmd_wr) begin
            case (op)
                `CFA_OP_ADD, `CFA_OP_ADC: begin
                    r8 = sum9[7:0];
                    acc_nxt = r8;
                    flags_nxt[`CFA_SIGN_ERR] = (acc_r[7] == opb_r[7]) &
                                               (r8[7] != acc_r[7]); // [RULE2]
                    flags_nxt[`CFA_NIBBLE_C] = sum5[4];            // [RULE3]
                    flags_nxt[`CFA_BORROW]   = sum9[8];            // [RULE12]
                end
                `CFA_OP_SUB, `CFA_OP_SBC: begin
                    r8 = dif9[7:0];
                    acc_nxt = r8;
                    flags_nxt[`CFA_SIGN_ERR] = (acc_r[7] != opb_r[7]) &
                                               (r8[7] != acc_r[7]); // [RULE2]
                    flags_nxt[`CFA_BORROW]   = dif9[8];            // [RULE12]
                end
                `CFA_OP_AND, `CFA_OP_OR, `CFA_OP_EOR: begin
                    if (op == `CFA_OP_AND) begin
                        r8 = acc_r & opb_r;
                    end else if (op == `CFA_OP_OR) begin
                        r8 = acc_r | opb_r;
                    end else begin
                        r8 = acc_r ^ opb_r;
                    end
                    acc_nxt = r8;
                    flags_nxt[`CFA_SIGN_ERR] = 1'b0;
                end
                `CFA_OP_LD8, `CFA_OP_ST8: begin
                    // a store leaves acc alone and flags its value
                    r8 = (op == `CFA_OP_LD8) ? opb_r : acc_r;
                    acc_nxt = r8;
                    flags_nxt[`CFA_SIGN_ERR] = 1'b0;
                end
                `CFA_OP_BCD: begin
                    // correction uses nibble and borrow flags of the add
                    lo_fix = flags_r[`CFA_NIBBLE_C] | (acc_r[3:0] > 4'h9);
                    hi_fix = flags_r[`CFA_BORROW] | (acc_r > 8'h99);
                    corr   = {1'b0, hi_fix, hi_fix, 2'b00, lo_fix, lo_fix,
                              1'b0};
                    r8 = acc_r + corr;                             // [RULE4]
                    acc_nxt = r8;
                    flags_nxt[`CFA_BORROW] = hi_fix;               // [RULE4]
                end
                `CFA_OP_LSL, `CFA_OP_ROL: begin
                    r8 = {acc_r[6:0], (op == `CFA_OP_ROL) &
                          flags_r[`CFA_BORROW]};
                    acc_nxt = r8;
                    flags_nxt[`CFA_BORROW]   = acc_r[7];           // [RULE13]
                    flags_nxt[`CFA_SIGN_ERR] = r8[7] ^ acc_r[7];
                end
                `CFA_OP_LSR, `CFA_OP_ROR: begin
                    r8 = {(op == `CFA_OP_ROR) & flags_r[`CFA_BORROW],
                          acc_r[7:1]};
                    acc_nxt = r8;
                    flags_nxt[`CFA_BORROW]   = acc_r[0];           // [RULE13]
                    flags_nxt[`CFA_SIGN_ERR] = r8[7] ^ acc_r[0];
                end
                default: ;
            endcase
            // msb and zero flags for every 8-bit result above
            if (op <= `CFA_OP_ST8 && op != `CFA_OP_LD16 &&
                op != `CFA_OP_BTB) begin
                res_nxt = {8'h00, r8};
                flags_nxt[`CFA_MSB]  = r8[7];         // [RULE8] [RULE9]
                flags_nxt[`CFA_NULL] = (r8 == 8'h00); // [RULE10] [RULE11]
            end
            case (op)
                `CFA_OP_LD16: begin
                    // inline 16-bit value: first byte is the high half
                    res_nxt = bytes_r;                             // [RULE19]
                    flags_nxt[`CFA_MSB]      = bytes_r[15];        // [RULE9]
                    flags_nxt[`CFA_NULL]     = (bytes_r == 16'h0); // [RULE11]
                    flags_nxt[`CFA_SIGN_ERR] = 1'b0;
                end
                `CFA_OP_BTB: begin
                    // operand fetched by source mode, target relative
                    cond = opb_r[cmd_nxt[`CFA_CMD_BIT_HI:`CFA_CMD_BIT_LO]];
                    flags_nxt[`CFA_BORROW] = cond;                 // [RULE13]
                    taken_nxt = (cond == cmd_nxt[`CFA_CMD_COND]);
                    if (taken_nxt) begin
                        pc_nxt = pc_r + {{8{bytes_r[7]}},
                                         bytes_r[7:0]};            // [RULE16]
                    end
                end
                `CFA_OP_BRANCH: begin
                    taken_nxt = cmd_nxt[`CFA_CMD_COND];
                    if (taken_nxt) begin
                        pc_nxt = pc_r + {{8{bytes_r[15]}},
                                         bytes_r[15:8]};           // [RULE18]
                    end
                end
                `CFA_OP_MCLR: begin
                    flags_nxt[`CFA_MASKED] = 1'b0;
                    if (flags_r[`CFA_MASKED]) begin
                        inhibit_nxt = 1'b1;                        // [RULE7]
                    end
                end
                `CFA_OP_MSET, `CFA_OP_IENTRY: begin
                    // entry: the sequencer issues this once stacking ends
                    flags_nxt[`CFA_MASKED] = 1'b1;                 // [RULE6]
                end
                `CFA_OP_A2F: begin
                    flags_nxt = cfa_fix(acc_r);
                    if (flags_r[`CFA_MASKED] & ~acc_r[`CFA_MASKED]) begin
                        inhibit_nxt = 1'b1;                        // [RULE7]
                    end
                end
                `CFA_OP_F2A: begin
                    acc_nxt = flags_r;
                    res_nxt = {8'h00, flags_r};
                end
                default: ;
            endcase
        end
    end

    // read mux; source and destination are formed apart [RULE15]
    always @* begin
        rd_nxt = 32'h0;
        case (wb_adr_i)
            `CFA_OFS_FLAGS:  rd_nxt = {24'h0, flags_r};
            `CFA_OFS_ACC:    rd_nxt = {24'h0, acc_r};
            `CFA_OFS_OPB:    rd_nxt = {24'h0, opb_r};
            `CFA_OFS_BYTES:  rd_nxt = {16'h0, bytes_r};
            `CFA_OFS_MODE:   rd_nxt = {28'h0, mode_r};
            `CFA_OFS_PC:     rd_nxt = {16'h0, pc_r};
            `CFA_OFS_CMD:    rd_nxt = {23'h0, cmd_r};
            `CFA_OFS_RESULT: rd_nxt = {16'h0, res_r};
            `CFA_OFS_ADDR:   rd_nxt = {dst_ea[15:0], src_ea[15:0]};
            `CFA_OFS_STATUS: rd_nxt = {28'h0, taken_r, inhibit_r,
                                       dst_ea[16], src_ea[16]};
            default:         rd_nxt = 32'h0;
        endcase
    end

    // state registers; the inhibit set wins over a same-cycle boundary
    always @(posedge clk_i) begin
        if (reset_i) begin
            flags_r    <= `CFA_FLAGS_RST;
            acc_r      <= 8'h00;
            opb_r      <= 8'h00;
            bytes_r    <= 16'h0000;
            mode_r     <= 4'h0;
            pc_r       <= `CFA_PC_RST;
            cmd_r      <= 9'h000;
            res_r      <= 16'h0000;
            inhibit_r  <= 1'b0;
            taken_r    <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h0;
            irq_take_o <= 1'b0;
            irq_mask_o <= 1'b1;
        end else begin
            flags_r    <= cfa_fix(flags_nxt);                      // [RULE1]
            acc_r      <= acc_nxt;
            opb_r      <= opb_nxt;
            bytes_r    <= bytes_nxt;
            mode_r     <= mode_nxt;
            pc_r       <= pc_nxt;
            cmd_r      <= cmd_nxt;
            res_r      <= res_nxt;
            inhibit_r  <= inhibit_nxt;
            taken_r    <= taken_nxt;
            // every request, mapped or not, is acked one edge later
            wb_ack_o   <= req;
            wb_dat_o   <= (req & ~wb_we_i) ? rd_nxt : 32'h0;
            // masked or inside the post-clear window: refuse [RULE5] [RULE7]
            irq_take_o <= boundary_i & irq_req_i & ~flags_r[`CFA_MASKED] &
                          ~inhibit_r;
            irq_mask_o <= flags_nxt[`CFA_MASKED];                  // [RULE5]
        end
    end

endmodule // cfa_core

// ---- design/cfa_defs.vh ----
// cfa_defs.vh: constants of the flags and operand addressing block.
// assumes it is included by bare name from the design and verification files.
`ifndef CFA_DEFS_VH
`define CFA_DEFS_VH

// register byte offsets on the wishbone slave
`define CFA_OFS_FLAGS   8'h00
`define CFA_OFS_ACC     8'h04
`define CFA_OFS_OPB     8'h08
`define CFA_OFS_BYTES   8'h0c
`define CFA_OFS_MODE    8'h10
`define CFA_OFS_PC      8'h14
`define CFA_OFS_CMD     8'h18
`define CFA_OFS_RESULT  8'h1c
`define CFA_OFS_ADDR    8'h20
`define CFA_OFS_STATUS  8'h24

// flags_register bit positions
`define CFA_SIGN_ERR    7
`define CFA_ONE_HI      6
`define CFA_ONE_LO      5
`define CFA_NIBBLE_C    4
`define CFA_MASKED      3
`define CFA_MSB         2
`define CFA_NULL        1
`define CFA_BORROW      0

// reset values and the fixed-one mask
`define CFA_FLAGS_RST   8'h68
`define CFA_ONES_MASK   8'h60
`define CFA_PC_RST      16'h0000

// addressing modes
`define CFA_MODE_REG    2'h0
`define CFA_MODE_BRANCH 2'h1
`define CFA_MODE_INLINE 2'h2
`define CFA_MODE_ZPAGE  2'h3

// command register fields
`define CFA_CMD_OP_HI   4
`define CFA_CMD_BIT_LO  5
`define CFA_CMD_BIT_HI  7
`define CFA_CMD_COND    8

// operation codes
`define CFA_OP_ADD      5'h00
`define CFA_OP_ADC      5'h01
`define CFA_OP_SUB      5'h02
`define CFA_OP_SBC      5'h03
`define CFA_OP_AND      5'h04
`define CFA_OP_OR       5'h05
`define CFA_OP_EOR      5'h06
`define CFA_OP_LD8      5'h07
`define CFA_OP_LD16     5'h08
`define CFA_OP_BCD      5'h09
`define CFA_OP_LSL      5'h0a
`define CFA_OP_LSR      5'h0b
`define CFA_OP_ROL      5'h0c
`define CFA_OP_ROR      5'h0d
`define CFA_OP_BTB      5'h0e
`define CFA_OP_ST8      5'h0f
`define CFA_OP_MCLR     5'h10
`define CFA_OP_MSET     5'h11
`define CFA_OP_A2F      5'h12
`define CFA_OP_F2A      5'h13
`define CFA_OP_IENTRY   5'h14
`define CFA_OP_BRANCH   5'h15

`endif

// ---- verif/cfa_core_props.sv ----
// cfa_core_props.sv: concurrent checks on the ports of cfa_core.
// assumes a classic wishbone master and a one-cycle boundary pulse.
`timescale 1ns/1ns
`include "cfa_defs.vh"
module cfa_core_props (
    // clock and reset
    input wire        clk_i,
    input wire        reset_i,
    // wishbone slave side
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // interrupt gating
    input wire        irq_req_i,
    input wire        boundary_i,
    input wire        irq_take_o,
    input wire        irq_mask_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // request taken at this edge, command write, flags read answer
    wire req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire cmd_w = req_w & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CFA_OFS_CMD);
    wire rdf_w = wb_ack_o & ~wb_we_i & (wb_adr_i == `CFA_OFS_FLAGS);
    reg  inh_r; // one boundary still owed after a mask clear
    // a set wins over a boundary in the same cycle; a flags load that
    // leaves the mask set opens no window, so a set mask drops the flag
    always @(posedge clk_i) begin
        if (reset_i)
            inh_r <= 1'b0;
        else if (cmd_w && irq_mask_o && (wb_dat_i[4:0] == `CFA_OP_MCLR ||
                 wb_dat_i[4:0] == `CFA_OP_A2F))
            inh_r <= 1'b1;
        else if (boundary_i || irq_mask_o)
            inh_r <= 1'b0;
    end
    AST_ACK_ONE:
        assert property (req_w |=> wb_ack_o) else $error("ack late");
    AST_ACK_DROP:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    AST_DAT_IDLE:
        assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
            else $error("read data outside ack");
    AST_FLAGS_ONES:
        assert property (rdf_w |-> wb_dat_o[6:5] == 2'b11)
            else $error("flags bits 6 and 5 not one");
    AST_FLAGS_MASK:
        assert property (rdf_w |-> wb_dat_o[3] == irq_mask_o)
            else $error("mask output differs from flags");
    AST_TAKE_CAUSE:
        assert property (irq_take_o |-> $past(boundary_i) && $past(irq_req_i))
            else $error("take without boundary and request");
    AST_MASK_BLOCKS:
        assert property (boundary_i && irq_mask_o && $past(irq_mask_o)
            |=> !irq_take_o) else $error("take while masked");
    AST_INHIBIT:
        assert property (boundary_i && inh_r |=> !irq_take_o)
            else $error("take right after mask clear");
    AST_ENTRY_MASK:
        assert property (cmd_w && wb_dat_i[4:0] == `CFA_OP_IENTRY
            |-> ##[1:2] irq_mask_o) else $error("entry left mask clear");
    AST_TAKE_GRANT:
        assert property (boundary_i && irq_req_i && !irq_mask_o && !inh_r
            && !$past(req_w) |=> irq_take_o) else $error("take missing");
    cover property (irq_take_o);
    cover property (boundary_i && inh_r);
    cover property (rdf_w);
endmodule // cfa_core_props

bind cfa_core cfa_core_props u_props (.clk_i(clk_i), .reset_i(reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req_i(irq_req_i),
    .boundary_i(boundary_i), .irq_take_o(irq_take_o),
    .irq_mask_o(irq_mask_o));

// ---- verif/cfa_seq_model.sv ----
// cfa_seq_model.sv: instruction sequencer standing beside the block.
// assumes the caller runs on clk_i; outputs move right after an edge.
`timescale 1ns/1ns
module cfa_seq_model (
    // clock
    input  wire clk_i,
    // toward the block
    input  wire irq_take_i,
    output reg  boundary_o,
    output reg  irq_req_o
);
    initial begin
        boundary_o = 1'b0;
        irq_req_o  = 1'b0;
    end
    // one boundary pulse with the request level; report the grant
    task step(input req, output taken);
        begin
            @(posedge clk_i);
            boundary_o <= 1'b1;
            irq_req_o  <= req;
            @(posedge clk_i);
            boundary_o <= 1'b0;
            irq_req_o  <= 1'b0;
            #1;
            taken = irq_take_i;
        end
    endtask
endmodule // cfa_seq_model

// ---- verif/cfa_tb_top.sv ----
// cfa_tb_top.sv: self-checking bench of cfa_core.
// assumes cfa_core, the sequencer model and the bound checker.
`timescale 1ns/1ns
`include "cfa_defs.vh"
module cpu_flags_and_operand_addressing_tb_top;
    reg         clk_i   = 1'b0;  // 25 MHz
    reg         reset_i = 1'b1;  // held 12 cycles
    reg         wb_cyc  = 1'b0;
    reg         wb_stb  = 1'b0;
    reg         wb_we   = 1'b0;
    reg  [7:0]  wb_adr  = 8'h00;
    reg  [3:0]  wb_sel  = 4'h0;
    reg  [31:0] wb_wdat = 32'h0;
    wire [31:0] wb_rdat;
    wire        wb_ack;
    wire        boundary;
    wire        irq_req;
    wire        irq_take;
    wire        irq_mask;
    integer     fails = 0;
    integer     comparisons = 0;
    reg  [31:0] rd;              // last read word
    reg         tk;              // last grant seen
    always #20 clk_i = ~clk_i;
    cfa_core dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .irq_req_i(irq_req), .boundary_i(boundary),
        .irq_take_o(irq_take), .irq_mask_o(irq_mask));
    cfa_seq_model seq (.clk_i(clk_i), .irq_take_i(irq_take),
        .boundary_o(boundary), .irq_req_o(irq_req));
    task test_done;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // classic single cycle; held until ack is seen, bounded wait
    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_i);
            {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
            wb_adr  <= a;
            wb_sel  <= 4'h3;
            wb_wdat <= d;
            n = 0;
            do begin
                @(posedge clk_i);
                #1;
                n = n + 1;
            end while (wb_ack !== 1'b1 && n < 16);
            if (n >= 16) begin
                fails = fails + 1;
                $display("Error wishbone ack expected 1 seen 0");
                test_done;
            end
            rd = wb_rdat;
            @(posedge clk_i);
            {wb_cyc, wb_stb, wb_we} <= 3'b000;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d);
    endtask
    task rdr(input [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    task t_regs;
        begin
            rdr(`CFA_OFS_FLAGS);
            chk("flags reset", 32'h68, rd);
            chk("mask reset", 32'h1, {31'h0, irq_mask});
            wr(`CFA_OFS_FLAGS, 32'h0);
            rdr(`CFA_OFS_FLAGS);
            chk("flags ones", 32'h60, rd);
            wr(8'h28, 32'hffff);
            rdr(8'h28);
            chk("unmapped", 32'h0, rd);
            wr(`CFA_OFS_RESULT, 32'h1234);
            rdr(`CFA_OFS_RESULT);
            chk("result read-only", 32'h0, rd);
            $display("test regs done");
        end
    endtask
    // v packs {acc, operand, preset flags, expected flags, expected acc}
    task alu(input [4:0] op, input [39:0] v);
        begin
            wr(`CFA_OFS_FLAGS, {24'h0, v[23:16]});
            wr(`CFA_OFS_ACC, {24'h0, v[39:32]});
            wr(`CFA_OFS_OPB, {24'h0, v[31:24]});
            wr(`CFA_OFS_CMD, {27'h0, op});
            rdr(`CFA_OFS_FLAGS);
            chk("flags", {24'h0, v[15:8]}, rd);
            rdr(`CFA_OFS_ACC);
            chk("acc", {24'h0, v[7:0]}, rd);
        end
    endtask
    task t_alu;
        alu(`CFA_OP_ADD, 40'h7f_01_60_f4_80);
        alu(`CFA_OP_ADD, 40'hff_01_60_73_00);
        alu(`CFA_OP_ADC, 40'h0e_01_61_70_10);
        alu(`CFA_OP_SUB, 40'h00_01_60_65_ff);
        alu(`CFA_OP_SBC, 40'h80_00_61_e0_7f);
        alu(`CFA_OP_AND, 40'hf0_0f_e1_63_00);
        alu(`CFA_OP_OR, 40'h00_00_e5_63_00);
        alu(`CFA_OP_EOR, 40'hff_0f_61_65_f0);
        alu(`CFA_OP_LD8, 40'h00_80_62_64_80);
        alu(`CFA_OP_ST8, 40'h00_55_64_62_00);
        alu(`CFA_OP_BCD, 40'h9a_00_60_63_00);
        alu(`CFA_OP_BCD, 40'h32_00_70_70_38);
        alu(`CFA_OP_LSL, 40'h81_00_60_e1_02);
        alu(`CFA_OP_LSR, 40'h01_00_60_e3_00);
        alu(`CFA_OP_ROL, 40'h80_00_61_e1_01);
        alu(`CFA_OP_ROR, 40'h01_00_60_e3_00);
        alu(`CFA_OP_MSET, 40'h12_00_60_68_12);
        alu(`CFA_OP_F2A, 40'h12_00_75_75_75);
        alu(`CFA_OP_A2F, 40'h00_00_60_60_00);
        alu(5'h1f, 40'h12_00_f5_f5_12);
        $display("test alu done");
    endtask
    task t_addr;
        wr(`CFA_OFS_PC, 32'h1000);
        wr(`CFA_OFS_BYTES, 32'h5a34);
        wr(`CFA_OFS_MODE, 32'h0b);
        rdr(`CFA_OFS_ADDR);
        chk("addr zpage inline", 32'h1001005a, rd);
        rdr(`CFA_OFS_STATUS);
        chk("access", 32'h3, rd & 32'h3);
        wr(`CFA_OFS_MODE, 32'h0d);
        rdr(`CFA_OFS_ADDR);
        chk("addr branch zpage", 32'h00341001, rd);
        wr(`CFA_OFS_MODE, 32'h0);
        rdr(`CFA_OFS_STATUS);
        chk("no access", 32'h0, rd & 32'h3);
        wr(`CFA_OFS_BYTES, 32'hfe00);
        wr(`CFA_OFS_CMD, {23'h0, 1'b1, 3'h0, `CFA_OP_BRANCH});
        rdr(`CFA_OFS_PC);
        chk("branch back", 32'h0ffe, rd);
        wr(`CFA_OFS_CMD, {23'h0, 1'b0, 3'h0, `CFA_OP_BRANCH});
        rdr(`CFA_OFS_PC);
        chk("branch not taken", 32'h0ffe, rd);
        wr(`CFA_OFS_FLAGS, 32'h60);
        wr(`CFA_OFS_OPB, 32'h04);
        wr(`CFA_OFS_BYTES, 32'h0010);
        wr(`CFA_OFS_CMD, {23'h0, 1'b1, 3'h2, `CFA_OP_BTB});
        rdr(`CFA_OFS_PC);
        chk("bit branch", 32'h100e, rd);
        rdr(`CFA_OFS_FLAGS);
        chk("bit carry", 32'h61, rd);
        wr(`CFA_OFS_BYTES, 32'h0080);
        wr(`CFA_OFS_CMD, {27'h0, `CFA_OP_LD16});
        rdr(`CFA_OFS_FLAGS);
        chk("ld16 low msb", 32'h61, rd);
        wr(`CFA_OFS_BYTES, 32'h8000);
        wr(`CFA_OFS_CMD, {27'h0, `CFA_OP_LD16});
        rdr(`CFA_OFS_FLAGS);
        chk("ld16 high msb", 32'h65, rd);
        $display("test addr done");
    endtask
    task t_irq;
        wr(`CFA_OFS_FLAGS, 32'h68);
        seq.step(1'b1, tk);
        chk("take masked", 32'h0, {31'h0, tk});
        wr(`CFA_OFS_CMD, {27'h0, `CFA_OP_MCLR});
        seq.step(1'b1, tk);
        chk("take after clear", 32'h0, {31'h0, tk});
        seq.step(1'b1, tk);
        chk("take open", 32'h1, {31'h0, tk});
        seq.step(1'b0, tk);
        chk("take idle", 32'h0, {31'h0, tk});
        wr(`CFA_OFS_CMD, {27'h0, `CFA_OP_IENTRY});
        rdr(`CFA_OFS_FLAGS);
        chk("entry flags", 32'h68, rd);
        chk("entry mask", 32'h1, {31'h0, irq_mask});
        seq.step(1'b1, tk);
        chk("take in handler", 32'h0, {31'h0, tk});
        $display("test irq done");
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs;
        t_alu;
        t_addr;
        t_irq;
        test_done;
    end
endmodule // cpu_flags_and_operand_addressing_tb_top
